// >>> inc/clid_pkg.sv
/*
  Shared constants and types of the character display instruction decoder:
  field positions, address limits, reset values and
  execution timing derived from the internal oscillator rate.
  Assumes a single system clock at CLK_HZ; all timing counts derive from it.
*/
package clid_pkg;

    // system clock and internal oscillator rates
    localparam longint CLK_HZ = 10_000_000;
    localparam longint OSC_HZ = 270_000;
    localparam int OSC_DIV = int'(CLK_HZ / OSC_HZ);
    localparam logic [5:0] OSC_DIV_LAST = 6'(OSC_DIV - 1);

    // execution times in ns, as oscillator ticks rounded up
    localparam longint LONG_EXEC_NS = 1_520_000;
    localparam longint SHORT_EXEC_NS = 38_000;
    localparam longint NS_PER_S = 1_000_000_000;
    localparam logic [8:0] LONG_TICKS = 9'((LONG_EXEC_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [8:0] SHORT_TICKS = 9'((SHORT_EXEC_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);

    // cursor blink half period in oscillator ticks (default only)
    localparam int BLINK_HALF_TICKS_DEF = 110_000;

    // instruction byte bit positions
    localparam int B_IDSET = 1;   // entry mode: direction
    localparam int B_SHEN = 0;    // entry mode: shift enable
    localparam int B_DON = 2;     // on/off: display
    localparam int B_CON = 1;     // on/off: cursor
    localparam int B_BON = 0;     // on/off: blink
    localparam int B_SC = 3;      // shift: display/cursor select
    localparam int B_RL = 2;      // shift: right/left
    localparam int B_BW = 4;      // function set: bus width
    localparam int B_NL = 3;      // function set: line count
    localparam int B_FT = 2;      // function set: font
    localparam int B_BUSY = 7;    // status byte: busy flag

    // address map of the display ram
    localparam logic [6:0] AC_ZERO = 7'h00;
    localparam logic [6:0] L1_LAST_2L = 7'h27;
    localparam logic [6:0] L2_FIRST = 7'h40;
    localparam logic [6:0] L2_LAST_2L = 7'h67;
    localparam logic [6:0] LAST_1L = 7'h4f;
    localparam logic [6:0] SPAN_2L_LAST = 7'h27;  // shift wraps after 40 columns
    localparam logic [6:0] SPAN_1L_LAST = 7'h4f;  // shift wraps after 80 columns
    localparam logic [6:0] FILL_LAST = 7'h7f;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    // reset values of the mode flags
    localparam logic RST_INC = 1'b1;
    localparam logic RST_BUS8 = 1'b1;

    // synchronised pin group
    typedef struct packed {
        logic e;
        logic rs;
        logic rw;
        logic [7:0] db;
    } clid_pins_t;

    // display state seen by the pixel drive
    typedef struct packed {
        logic disp_on;
        logic cursor_on;
        logic blink_on;
        logic blink_solid;
        logic two_line;
        logic font_tall;
        logic bus8;
        logic [6:0] shift;
    } clid_view_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FILL = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_LOAD = 4'b1000
    } clid_state_t;

endpackage : clid_pkg

// >>> core/clid_sync.sv
/*
  Two-flop synchroniser for a group of pins.
  Assumes inputs are asynchronous to CLK_I; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module clid_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // two stages, reset to zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;

endmodule : clid_sync

// >>> core/clid_ram.sv
/*
  Single-port synchronous ram with registered read data.
  Assumes one access per clock; read returns the old word on a same-address write.
*/
`timescale 1ns/1ps
module clid_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_ff;

    // write port and registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_ff <= mem[addr_i];
    end

    assign rdata_o = rdata_ff;

endmodule : clid_ram

// >>> core/clid_core.sv
/*
  Instruction decoder of a 16x2 character display controller: host pin
  interface (8 or 4 bit), instruction decode, address counter, shift state,
  display flags, display and pattern ram, busy timing.
  Assumes host pins are asynchronous and E pulses last at least 3 clocks.
*/
`timescale 1ns/1ps
module clid_core
    import clid_pkg::*;
#(
    parameter int BLINK_HALF_TICKS = BLINK_HALF_TICKS_DEF
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic BUS_E_I,
    input wire logic REG_SELECT_I,
    input wire logic BUS_RW_I,
    input wire logic [7:0] BUS_LINES_I,
    output logic [7:0] BUS_LINES_O,
    output logic BUS_LINES_OE_O,
    output logic BUSY_FLAG_O,
    output logic [6:0] ADDR_COUNTER_O,
    output clid_view_t DISPLAY_STATE_O
);

    // step the address counter with wrap per ram and line mode
    function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up, input logic cg,
                                           input logic two);
        logic [6:0] r;
        r = a;
        if (cg) begin
            r = {1'b0, up ? 6'(a[5:0] + 6'h01) : 6'(a[5:0] - 6'h01)};
        end else if (two) begin
            // line one ends at column 40, then line two
            if (up) begin
                r = (a == L1_LAST_2L) ? L2_FIRST : (a == L2_LAST_2L) ? AC_ZERO : 7'(a + 7'h01);
            end else begin
                r = (a == L2_FIRST) ? L1_LAST_2L : (a == AC_ZERO) ? L2_LAST_2L : 7'(a - 7'h01);
            end
        end else begin
            if (up) begin
                r = (a == LAST_1L) ? AC_ZERO : 7'(a + 7'h01);
            end else begin
                r = (a == AC_ZERO) ? LAST_1L : 7'(a - 7'h01);
            end
        end
        return r;
    endfunction : step_ac

    // move the display window by one column; one offset serves both lines
    function automatic logic [6:0] step_shift(input logic [6:0] s, input logic left, input logic two);
        logic [6:0] last;
        logic [6:0] r;
        last = two ? SPAN_2L_LAST : SPAN_1L_LAST;
        if (left) begin
            r = (s == last) ? AC_ZERO : 7'(s + 7'h01);
        end else begin
            r = (s == AC_ZERO) ? last : 7'(s - 7'h01);
        end
        return r;
    endfunction : step_shift

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and strobe edges

    clid_pins_t pins_raw;
    clid_pins_t pins_s;
    logic e_d_ff;
    logic e_rise;
    logic e_fall;

    assign pins_raw = '{e: BUS_E_I, rs: REG_SELECT_I, rw: BUS_RW_I, db: BUS_LINES_I};

    clid_sync #(.W($bits(clid_pins_t))) u_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    // previous strobe level for edge detection
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            e_d_ff <= 1'b0;
        end else begin
            e_d_ff <= pins_s.e;
        end
    end

    assign e_rise = pins_s.e & ~e_d_ff;
    assign e_fall = ~pins_s.e & e_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // state declarations

    clid_state_t state_ff;
    logic [6:0] ac_ff;
    logic cg_sel_ff;
    logic inc_ff;
    logic shen_ff;
    logic disp_on_ff;
    logic cursor_on_ff;
    logic blink_on_ff;
    logic bus8_ff;
    logic two_line_ff;
    logic font_ff;
    logic [6:0] shift_ff;
    logic [6:0] fill_cnt_ff;
    logic [8:0] busy_cnt_ff;
    logic [5:0] osc_cnt_ff;
    logic osc_tick;
    logic phase_ff;
    logic [3:0] hi_nib_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] out_ff;
    logic oe_ff;
    logic busy;
    logic byte_done;
    logic [7:0] wr_byte;
    logic accept;

    // ram ports
    logic dd_we;
    logic cg_we;
    logic [6:0] dd_addr;
    logic [7:0] dd_wdata;
    logic [7:0] dd_rdata;
    logic [7:0] cg_rdata;

    assign busy = (busy_cnt_ff != 9'h000) || (state_ff != ST_IDLE);
    // a byte completes on every strobe in 8-bit mode, on the second one in 4-bit mode
    assign byte_done = e_fall & (bus8_ff | phase_ff);
    assign wr_byte = bus8_ff ? pins_s.db : {hi_nib_ff, pins_s.db[7:4]};
    // accesses during execution are dropped; status reads always go through
    assign accept = byte_done & ~busy;

    ////////////////////////////////////////////////////////////////////////
    // oscillator tick divider and busy timer

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            osc_cnt_ff <= 6'h00;
        end else begin
            osc_cnt_ff <= (osc_cnt_ff == OSC_DIV_LAST) ? 6'h00 : 6'(osc_cnt_ff + 6'h01);
        end
    end

    assign osc_tick = (osc_cnt_ff == OSC_DIV_LAST);

    // load on acceptance, count down in oscillator ticks
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_cnt_ff <= 9'h000;
        end else if (accept && !(pins_s.rw && !pins_s.rs)) begin
            if (!pins_s.rs && !pins_s.rw && (wr_byte[7:2] == 6'h00) && (wr_byte[1:0] != 2'b00)) begin
                busy_cnt_ff <= LONG_TICKS;
            end else begin
                busy_cnt_ff <= SHORT_TICKS;
            end
        end else if (osc_tick && busy_cnt_ff != 9'h000) begin
            busy_cnt_ff <= 9'(busy_cnt_ff - 9'h001);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nibble pairing for the narrow bus, high nibble first

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phase_ff <= 1'b0;
            hi_nib_ff <= NIB_ZERO;
        end else if (e_fall) begin
            if (bus8_ff) begin
                phase_ff <= 1'b0;
            end else begin
                phase_ff <= ~phase_ff;
                if (!phase_ff) begin
                    hi_nib_ff <= pins_s.db[7:4];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read drive: status or data byte, captured at strobe rise

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            out_ff <= 8'h00;
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= pins_s.e & pins_s.rw;
            if (e_rise && pins_s.rw) begin
                // register select high reads ram, low reads status
                logic [7:0] b;
                b = pins_s.rs ? rd_data_ff : {busy, ac_ff};
                if (bus8_ff) begin
                    out_ff <= b;
                end else begin
                    out_ff <= {phase_ff ? b[3:0] : b[7:4], NIB_ZERO};
                end
            end
        end
    end

    assign BUS_LINES_O = out_ff;
    assign BUS_LINES_OE_O = oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // instruction and data execution

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= ST_IDLE;
            ac_ff <= AC_ZERO;
            cg_sel_ff <= 1'b0;
            inc_ff <= RST_INC;
            shen_ff <= 1'b0;
            disp_on_ff <= 1'b0;
            cursor_on_ff <= 1'b0;
            blink_on_ff <= 1'b0;
            bus8_ff <= RST_BUS8;
            two_line_ff <= 1'b0;
            font_ff <= 1'b0;
            shift_ff <= AC_ZERO;
            fill_cnt_ff <= AC_ZERO;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (accept && !pins_s.rs && !pins_s.rw) begin
                        // priority on the highest set bit
                        casez (wr_byte)
                            8'b1???????: begin
                                ac_ff <= wr_byte[6:0];
                                cg_sel_ff <= 1'b0;
                                state_ff <= ST_FETCH;
                            end
                            8'b01??????: begin
                                ac_ff <= {1'b0, wr_byte[5:0]};
                                cg_sel_ff <= 1'b1;
                                state_ff <= ST_FETCH;
                            end
                            8'b001?????: begin
                                bus8_ff <= wr_byte[B_BW];
                                two_line_ff <= wr_byte[B_NL];
                                font_ff <= wr_byte[B_FT];
                            end
                            8'b0001????: begin
                                if (wr_byte[B_SC]) begin
                                    // window moves, counter and ram untouched
                                    shift_ff <= step_shift(shift_ff, ~wr_byte[B_RL], two_line_ff);
                                end else begin
                                    ac_ff <= step_ac(ac_ff, wr_byte[B_RL], cg_sel_ff, two_line_ff);
                                    state_ff <= ST_FETCH;
                                end
                            end
                            8'b00001???: begin
                                disp_on_ff <= wr_byte[B_DON];
                                cursor_on_ff <= wr_byte[B_CON];
                                blink_on_ff <= wr_byte[B_BON];
                            end
                            8'b000001??: begin
                                inc_ff <= wr_byte[B_IDSET];
                                shen_ff <= wr_byte[B_SHEN];
                            end
                            8'b0000001?: begin
                                ac_ff <= AC_ZERO;
                                cg_sel_ff <= 1'b0;
                                shift_ff <= AC_ZERO;
                                state_ff <= ST_FETCH;
                            end
                            8'b00000001: begin
                                ac_ff <= AC_ZERO;
                                cg_sel_ff <= 1'b0;
                                inc_ff <= 1'b1;
                                shift_ff <= AC_ZERO;
                                fill_cnt_ff <= AC_ZERO;
                                state_ff <= ST_FILL;
                            end
                            default: begin
                                // all-zero byte is no instruction
                            end
                        endcase
                    end else if (accept && pins_s.rs) begin
                        // write or read: step counter, refresh the read register
                        ac_ff <= step_ac(ac_ff, inc_ff, cg_sel_ff, two_line_ff);
                        if (!pins_s.rw && shen_ff && !cg_sel_ff) begin
                            shift_ff <= step_shift(shift_ff, inc_ff, two_line_ff);
                        end
                        state_ff <= ST_FETCH;
                    end
                end
                ST_FILL: begin
                    fill_cnt_ff <= 7'(fill_cnt_ff + 7'h01);
                    if (fill_cnt_ff == FILL_LAST) begin
                        state_ff <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state_ff <= ST_LOAD;
                end
                ST_LOAD: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read register: prefetched after address set, cursor move and each access

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_data_ff <= 8'h00;
        end else if (state_ff == ST_LOAD) begin
            rd_data_ff <= cg_sel_ff ? cg_rdata : dd_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rams; the fill sweep owns the display ram while clearing

    assign dd_we = (state_ff == ST_FILL) || (accept && pins_s.rs && !pins_s.rw && !cg_sel_ff);
    assign cg_we = accept && pins_s.rs && !pins_s.rw && cg_sel_ff;
    assign dd_addr = (state_ff == ST_FILL) ? fill_cnt_ff : ac_ff;
    assign dd_wdata = (state_ff == ST_FILL) ? SPACE_CODE : wr_byte;

    clid_ram #(.AW(7), .DW(8)) u_display_ram (
        .clk_i(CLK_I),
        .we_i(dd_we),
        .addr_i(dd_addr),
        .wdata_i(dd_wdata),
        .rdata_o(dd_rdata)
    );

    clid_ram #(.AW(6), .DW(8)) u_pattern_ram (
        .clk_i(CLK_I),
        .we_i(cg_we),
        .addr_i(ac_ff[5:0]),
        .wdata_i(wr_byte),
        .rdata_o(cg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // cursor blink timing, in oscillator ticks

    logic [16:0] blink_cnt_ff;
    logic blink_phase_ff;
    logic blink_solid_ff;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            blink_cnt_ff <= 17'h00000;
            blink_phase_ff <= 1'b0;
            blink_solid_ff <= 1'b0;
        end else begin
            if (osc_tick) begin
                if (blink_cnt_ff == 17'(BLINK_HALF_TICKS - 1)) begin
                    blink_cnt_ff <= 17'h00000;
                    blink_phase_ff <= ~blink_phase_ff;
                end else begin
                    blink_cnt_ff <= 17'(blink_cnt_ff + 17'h00001);
                end
            end
            // cursor cell shows all dots on one half, character on the other
            blink_solid_ff <= disp_on_ff & blink_on_ff & blink_phase_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign BUSY_FLAG_O = busy;
    assign ADDR_COUNTER_O = ac_ff;
    assign DISPLAY_STATE_O = '{disp_on: disp_on_ff, cursor_on: cursor_on_ff & disp_on_ff,
                               blink_on: blink_on_ff, blink_solid: blink_solid_ff,
                               two_line: two_line_ff, font_tall: font_ff, bus8: bus8_ff,
                               shift: shift_ff};

endmodule : clid_core

// >>> testbench/clid_host_model.sv
/* host processor model on the parallel pins: polls status, then strobes.
   assumes the bench resolves the shared data lines. */
`timescale 1ns/1ps
module clid_host_model (
    input wire logic clk_i,
    input wire logic [7:0] db_i,
    output logic e_o,
    output logic rs_o,
    output logic rw_o,
    output logic [7:0] db_o
);
    logic nib = 1'b0; // four-bit transfers
    int stuck = 0; // polls that ran out
    // idle pins at time zero
    initial begin
        e_o = 1'b0;
        rs_o = 1'b0;
        rw_o = 1'b0;
        db_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // one e pulse; released lines show the inverse so stale data never matches
    task automatic strobe(input logic s, input logic w, input logic [7:0] x, output logic [7:0] y);
        @(posedge clk_i);
        #1;
        rs_o = s;
        rw_o = w;
        db_o = w ? ~db_o : x;
        @(posedge clk_i);
        #1 e_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 y = db_i;
        e_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 db_o = ~db_o;
    endtask : strobe
    // narrow bus: high nibble first on the upper lines
    task automatic xfer(input logic s, input logic w, input logic [7:0] x, output logic [7:0] y);
        logic [7:0] h;
        logic [7:0] l;
        if (nib) begin
            strobe(s, w, {x[7:4], 4'h0}, h);
            strobe(s, w, {x[3:0], 4'h0}, l);
            y = {h[7:4], l[7:4]};
        end else strobe(s, w, x, y);
    endtask : xfer
    // device drops anything sent while busy, so wait for the flag first
    task automatic access(input logic s, input logic w, input logic [7:0] x, output logic [7:0] y);
        logic [7:0] st;
        int k;
        st = 8'hff;
        k = 0;
        while (st[7] !== 1'b0 && k < 4000) begin
            xfer(1'b0, 1'b1, 8'h00, st);
            k++;
        end
        if (k == 4000) stuck++;
        xfer(s, w, x, y);
    endtask : access
endmodule : clid_host_model

// >>> testbench/clid_assertions.sv
/* checker on the decoder top ports, bound below.
   assumes rs and rw are held through each e pulse. */
`timescale 1ns/1ps
module clid_assertions
    import clid_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic BUS_E_I,
    input wire logic REG_SELECT_I,
    input wire logic BUS_RW_I,
    input wire logic [7:0] BUS_LINES_O,
    input wire logic BUS_LINES_OE_O,
    input wire logic BUSY_FLAG_O,
    input wire logic [6:0] ADDR_COUNTER_O,
    input wire clid_view_t DISPLAY_STATE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    property p_oe_read;
        $rose(BUS_LINES_OE_O) |-> $past(BUS_E_I, 3) && $past(BUS_RW_I, 3);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("drive without read");
    property p_busy_min;
        $rose(BUSY_FLAG_O) |-> BUSY_FLAG_O [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_cause;
        $rose(BUSY_FLAG_O) |-> !$past(BUS_E_I, 1) && ($past(REG_SELECT_I, 3) || !$past(BUS_RW_I, 3));
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy from status read");
    property p_oe_fall;
        $fell(BUS_LINES_OE_O) |-> !$past(BUS_E_I, 1);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("drive dropped early");
    property p_data_hold;
        BUS_LINES_OE_O && $past(BUS_LINES_OE_O) |-> $stable(BUS_LINES_O);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved");
    property p_status_ac;
        $rose(BUS_LINES_OE_O) && !$past(REG_SELECT_I, 3) && DISPLAY_STATE_O.bus8 && !BUSY_FLAG_O
            |-> BUS_LINES_O[6:0] == ADDR_COUNTER_O;
    endproperty
    a_status_ac: assert property (p_status_ac) else $error("status address wrong");
    property p_cursor_gate;
        !DISPLAY_STATE_O.disp_on && !$past(DISPLAY_STATE_O.disp_on)
            |-> !DISPLAY_STATE_O.cursor_on && !DISPLAY_STATE_O.blink_solid;
    endproperty
    a_cursor_gate: assert property (p_cursor_gate) else $error("cursor while blank");
    property p_solid_gate;
        DISPLAY_STATE_O.blink_solid |-> DISPLAY_STATE_O.blink_on || $past(DISPLAY_STATE_O.blink_on);
    endproperty
    a_solid_gate: assert property (p_solid_gate) else $error("blink while off");
endmodule : clid_assertions
bind clid_core clid_assertions u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .BUS_E_I(BUS_E_I),
    .REG_SELECT_I(REG_SELECT_I), .BUS_RW_I(BUS_RW_I), .BUS_LINES_O(BUS_LINES_O),
    .BUS_LINES_OE_O(BUS_LINES_OE_O), .BUSY_FLAG_O(BUSY_FLAG_O), .ADDR_COUNTER_O(ADDR_COUNTER_O),
    .DISPLAY_STATE_O(DISPLAY_STATE_O));

// >>> testbench/char_lcd_instruction_decoder_test.sv
/* self-checking bench for the decoder, driven through the host model.
   assumes a 10 mhz clock; blink half period shortened to 4 ticks. */
`timescale 1ns/1ps
module char_lcd_instruction_decoder_test;
    import clid_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic e, rs, rw, oe, busy;
    logic [7:0] hdb, ddb, q, r;
    logic [7:0] d [4];
    logic [6:0] ac, b;
    clid_view_t v;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    wire [7:0] bus = oe ? ddb : hdb; // shared data lines
    initial forever #50 clk = ~clk;
    clid_host_model u_host (.clk_i(clk), .db_i(bus), .e_o(e), .rs_o(rs), .rw_o(rw), .db_o(hdb));
    clid_core #(.BLINK_HALF_TICKS(4)) u_dut (.CLK_I(clk), .RST_I(rst), .BUS_E_I(e), .REG_SELECT_I(rs),
        .BUS_RW_I(rw), .BUS_LINES_I(bus), .BUS_LINES_O(ddb), .BUS_LINES_OE_O(oe), .BUSY_FLAG_O(busy),
        .ADDR_COUNTER_O(ac), .DISPLAY_STATE_O(v));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        cmp_count++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // expected counter after one increment in two-line mode
    function automatic logic [6:0] exp_inc2(input logic [6:0] a);
        return (a == 7'h27) ? 7'h40 : 7'(a + 7'h01);
    endfunction : exp_inc2
    task automatic op(input logic s, input logic w, input logic [7:0] x);
        u_host.access(s, w, x, q);
    endtask : op
    // busy span measured loosely: tick phase may shorten it by one tick
    task automatic timed(input logic [7:0] x, input int t);
        op(1'b0, 1'b0, x);
        u_host.xfer(1'b0, 1'b1, 8'h00, r);
        chk(r[7], 1'b1);
        n = 0;
        while (busy === 1'b1 && n < 20000) begin
            @(posedge clk) #1;
            n++;
        end
        chk(n > (t - 1) * OSC_DIV - 30 && n < t * OSC_DIV + 140, 1'b1);
    endtask : timed
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // watchdog well past the expected run of about 5 ms
    initial begin
        #9_000_000;
        n_fail++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        b = 7'($urandom(32'h97a5));
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk({ac, busy}, 8'h00);
        chk(v, 14'h0080);
        timed(8'h3c, SHORT_TICKS);
        chk({v.two_line, v.font_tall, v.bus8}, 3'b111);
        op(1'b0, 1'b0, 8'h06);
        b = 7'(8 + $urandom % 24);
        op(1'b0, 1'b0, 8'h80 | b);
        for (int i = 0; i < 4; i++) begin
            d[i] = 8'($urandom);
            op(1'b1, 1'b0, d[i]);
            chk(ac, exp_inc2(b + 7'(i)));
        end
        op(1'b0, 1'b0, 8'h80 | b);
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b1, 8'h00);
            chk(q, d[i]);
        end
        op(1'b0, 1'b0, 8'h04);
        op(1'b1, 1'b0, 8'h11);
        chk(ac, b + 7'h03);
        op(1'b0, 1'b0, 8'h06);
        op(1'b0, 1'b0, 8'ha7);
        op(1'b1, 1'b0, 8'h5a);
        chk(ac, exp_inc2(7'h27));
        op(1'b1, 1'b0, 8'ha5);
        op(1'b0, 1'b0, 8'hc0);
        op(1'b1, 1'b1, 8'h00);
        chk(q, 8'ha5);
        op(1'b0, 1'b0, 8'h7f);
        op(1'b1, 1'b0, 8'h1b);
        chk(ac, 7'h00);
        op(1'b0, 1'b0, 8'h7f);
        op(1'b1, 1'b1, 8'h00);
        chk(q, 8'h1b);
        $display("test ram access done");
        op(1'b0, 1'b0, 8'h85);
        op(1'b0, 1'b0, 8'h14);
        chk(ac, 7'h06);
        op(1'b0, 1'b0, 8'h10);
        chk(ac, 7'h05);
        op(1'b0, 1'b0, 8'h18);
        chk({v.shift, ac}, {7'h01, 7'h05});
        op(1'b0, 1'b0, 8'h1c);
        chk(v.shift, 7'h00);
        op(1'b0, 1'b0, 8'h07);
        op(1'b1, 1'b0, 8'h33);
        chk(v.shift, 7'h01);
        op(1'b1, 1'b1, 8'h00);
        chk(v.shift, 7'h01);
        op(1'b0, 1'b0, 8'h05);
        op(1'b1, 1'b0, 8'h33);
        chk(v.shift, 7'h00);
        op(1'b0, 1'b0, 8'h18);
        timed(8'h03, LONG_TICKS);
        chk({v.shift, ac}, 14'h0000);
        op(1'b0, 1'b0, 8'h80 | b);
        op(1'b1, 1'b1, 8'h00);
        chk(q, d[0]);
        $display("test shift and home done");
        for (int i = 0; i < 8; i++) begin
            op(1'b0, 1'b0, 8'h08 | 8'(i));
            chk({v.disp_on, v.cursor_on, v.blink_on}, {i[2], i[2] & i[1], i[0]});
        end
        n = 0;
        repeat (400) @(posedge clk) #1 n += int'(v.blink_solid);
        chk(n > 0 && n < 400, 1'b1);
        timed(8'h01, LONG_TICKS);
        chk({v.shift, ac}, 14'h0000);
        op(1'b1, 1'b0, 8'h44);
        chk(ac, 7'h01);
        op(1'b0, 1'b0, 8'h80 | b);
        op(1'b1, 1'b1, 8'h00);
        chk(q, SPACE_CODE);
        $display("test flags and clear done");
        op(1'b0, 1'b0, 8'h28);
        chk({v.font_tall, v.bus8}, 2'b00);
        u_host.nib = 1'b1;
        op(1'b0, 1'b0, 8'hc5);
        op(1'b1, 1'b0, 8'h3c);
        u_host.xfer(1'b0, 1'b1, 8'h00, r);
        chk(r[6:0], 7'h46);
        op(1'b0, 1'b0, 8'hc5);
        op(1'b1, 1'b1, 8'h00);
        chk(q, 8'h3c);
        chk(16'(u_host.stuck), 16'h0000);
        $display("test narrow bus done");
        end_of_test();
    end
endmodule : char_lcd_instruction_decoder_test
